//--- rtl/baeq_pkg.sv
// Types shared by the bus activity event qualifier.
// Assumes baeq_regs.svh supplies the numeric constants.
package baeq_pkg;
	// Data phase observation, one cycle sample.
	typedef struct packed {
		logic data_ready_signal;
		logic data_busy_signal;
		logic self_drives;
		logic self_samples;
	} baeq_phase_type;
	// One bus sequence queue allocation.
	typedef struct packed {
		logic [1:0] kind;
		logic [1:0] length;
		logic       io;
		logic       lock;
		logic       cacheable;
		logic       split;
		logic       demand;
		logic       ordered;
		logic [2:0] memory_kind;
		logic       from_self;
		logic [6:0] bytes;
		logic       l2_writeback;
	} baeq_alloc_type;
	// In-order queue allocation (older models).
	typedef struct packed {
		logic [4:0] kind;
		logic       is_read;
		logic       is_write;
		logic [4:0] memory_onehot;
		logic       from_self;
		logic [1:0] privilege_level;
	} baeq_ioq_type;
	typedef enum logic [1:0] {
		BAEQ_ST_IDLE  = 2'b00,
		BAEQ_ST_DATA  = 2'b01,
		BAEQ_ST_QUEUE = 2'b10
	} baeq_mode_type;
endpackage

//--- rtl/baeq_regs.svh
// Register offsets, field positions, codes and reset values of the qualifier.
// Included by the package user; definitions only.
`ifndef BAEQ_REGS_SVH
`define BAEQ_REGS_SVH
`define BAEQ_OFF_SEL_A      8'h00
`define BAEQ_OFF_SEL_Q      8'h04
`define BAEQ_OFF_CFG        8'h08
`define BAEQ_OFF_CNT_D      8'h0C
`define BAEQ_OFF_CNT_Q      8'h10
`define BAEQ_OFF_IOQ        8'h14
`define BAEQ_OFF_STAT       8'h18
`define BAEQ_SEL_LSB        25
`define BAEQ_SEL_MSB        31
`define BAEQ_MASK_LSB       9
`define BAEQ_MASK_MSB       24
`define BAEQ_CFG_LSB        13
`define BAEQ_CFG_MSB        15
`define BAEQ_EDGE_BIT       0
`define BAEQ_CODE_DATA      7'h17
`define BAEQ_CODE_QUEUE     7'h05
`define BAEQ_CFG_DATA       3'h6
`define BAEQ_CFG_QUEUE      3'h7
`define BAEQ_SEL_RST        32'h0000_0000
`define BAEQ_CFG_RST        32'h0000_0000
`define BAEQ_MEM_UC         3'h0
`define BAEQ_MEM_WC         3'h1
`define BAEQ_MEM_WT         3'h4
`define BAEQ_MEM_WP         3'h5
`define BAEQ_MEM_WB         3'h6
`define BAEQ_LINE_BYTES     7'h40
`endif

//--- rtl/baeq_top.sv
// Bus activity event qualifier: data phase and queue allocation counters.
// Assumes a classic Wishbone master on clk_i and bus pins from other agents.
// Operation
// - Data activity code counts matching ready/busy.
// - Mask bit0 counts self-driven data.
// - Mask bit1 counts self-sampled read data.
// - Mask bit2 counts unsampled bus data.
// - Ready lasts two or four clocks.
// - Mask bit3 counts self busy reserve.
// - Repeated busy reserve counts each time.
// - Mask bit4 counts busy for sampled data.
// - Owned and other never both true.
// - Queue code counts matching allocations.
// - Request kind in mask bits 0-1.
// - Request length in mask bits 2-3.
// - Mask bits 5-10 qualify requests.
// - Memory kind in mask bits 11-13.
// - L2 writeback counts its own entry.
// - WB read adds adjacent sector prefetch.
// - Under 64 bytes is a chunk entry.
// - Older in-order trigger equation.
// - In-order count ignores privilege level.
// - In-order entry is line or chunk.
// - Mask bit14 other, bit13 self source.
`timescale 1ns/1ps
`include "baeq_regs.svh"
`default_nettype none
module baeq_top #(
	parameter int CNT_W = 32
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [7:0]              adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	output logic                         ack_o,
	input  wire baeq_pkg::baeq_phase_type phase_i,
	input  wire logic                    alloc_valid_i,
	input  wire baeq_pkg::baeq_alloc_type alloc_i,
	input  wire logic                    ioq_valid_i,
	input  wire baeq_pkg::baeq_ioq_type  ioq_i,
	output logic                         data_event_o,
	output logic                         queue_event_o
);
	////////////////////////////////////////////////////////////////////////
	// Registers: selectors (select + mask), config, counters.
	logic [31:0]             sel_a;
	logic [31:0]             sel_q;
	logic [31:0]             cfg;
	logic [CNT_W-1:0]        cnt_d;
	logic [CNT_W-1:0]        cnt_q;
	logic [CNT_W-1:0]        cnt_i;
	logic                    wr;
	logic                    rd;
	baeq_pkg::baeq_phase_type ph1;
	baeq_pkg::baeq_phase_type ph2;
	logic [5:0]              cond;
	logic [5:0]              cond_q;
	logic                    hit_d;
	logic                    hit_dq;
	logic                    hit_q;
	logic                    hit_qq;
	logic                    hit_i;
	logic                    hit_iq;
	logic                    data_mode;
	logic                    queue_mode;
	logic                    edge_d;
	logic                    edge_q;
	logic                    pf_pend;
	logic                    wb_pend;
	logic                    chunk_q;
	logic [15:0]             md;
	logic [15:0]             mq;
	baeq_pkg::baeq_mode_type mode;

	assign wr = cyc_i & stb_i & we_i & ~ack_o;
	assign rd = cyc_i & stb_i & ~ack_o;
	assign md = sel_a[`BAEQ_MASK_MSB:`BAEQ_MASK_LSB];
	assign mq = sel_q[`BAEQ_MASK_MSB:`BAEQ_MASK_LSB];

	// Byte-lane merge for writes.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Ack one cycle after the strobe, then drop for one cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
		end
	end

	// Software writes to selectors and configuration.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_a <= `BAEQ_SEL_RST;
			sel_q <= `BAEQ_SEL_RST;
			cfg   <= `BAEQ_CFG_RST;
		end else if (wr) begin
			if (adr_i == `BAEQ_OFF_SEL_A) begin
				sel_a <= merge(sel_a, dat_i, sel_i);
			end
			if (adr_i == `BAEQ_OFF_SEL_Q) begin
				sel_q <= merge(sel_q, dat_i, sel_i);
			end
			if (adr_i == `BAEQ_OFF_CFG) begin
				cfg <= merge(cfg, dat_i, sel_i);
			end
		end
	end

	// Read mux; unmapped addresses read zero and still acknowledge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (rd) begin
			unique case (adr_i)
				`BAEQ_OFF_SEL_A: dat_o <= sel_a;
				`BAEQ_OFF_SEL_Q: dat_o <= sel_q;
				`BAEQ_OFF_CFG:   dat_o <= cfg;
				`BAEQ_OFF_CNT_D: dat_o <= 32'(cnt_d);
				`BAEQ_OFF_CNT_Q: dat_o <= 32'(cnt_q);
				`BAEQ_OFF_IOQ:   dat_o <= 32'(cnt_i);
				`BAEQ_OFF_STAT:  dat_o <= {27'h000_0000, chunk_q, pf_pend,
					wb_pend, mode};
				default:         dat_o <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus pins come from other agents, so they pass two flops first.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph1 <= '0;
			ph2 <= '0;
		end else begin
			ph1 <= phase_i;
			ph2 <= ph1;
		end
	end

	// Classify the data phase. Sampled and unsampled are exclusive by
	// construction because one is the inverse of the other. Ready lasts
	// two or four clocks; each clock is a condition, edge mode folds it.
	always_comb begin
		cond[0] = ph2.data_ready_signal & ph2.self_drives;
		cond[1] = ph2.data_ready_signal & ph2.self_samples;
		cond[2] = ph2.data_ready_signal & ~ph2.self_samples;
		cond[3] = ph2.data_busy_signal & ph2.self_drives;
		cond[4] = ph2.data_busy_signal & ph2.self_samples;
		cond[5] = ph2.data_busy_signal & ~ph2.self_samples;
	end

	assign data_mode  = sel_a[`BAEQ_SEL_MSB:`BAEQ_SEL_LSB]
		== `BAEQ_CODE_DATA
		&& cfg[`BAEQ_CFG_MSB:`BAEQ_CFG_LSB] == `BAEQ_CFG_DATA;
	assign queue_mode = sel_q[`BAEQ_SEL_MSB:`BAEQ_SEL_LSB]
		== `BAEQ_CODE_QUEUE
		&& cfg[`BAEQ_CFG_MSB:`BAEQ_CFG_LSB] == `BAEQ_CFG_QUEUE;
	assign edge_d = cfg[`BAEQ_EDGE_BIT];
	assign edge_q = cfg[`BAEQ_EDGE_BIT];
	assign mode = data_mode ? baeq_pkg::BAEQ_ST_DATA
		: queue_mode ? baeq_pkg::BAEQ_ST_QUEUE : baeq_pkg::BAEQ_ST_IDLE;

	// Data hit: any enabled mask bit sees its condition.
	assign hit_d = data_mode & |(cond & md[5:0]);

	////////////////////////////////////////////////////////////////////////
	// Queue allocation match. A selected field or bit must agree.
	function automatic logic qmatch(input baeq_pkg::baeq_alloc_type a,
		input logic [15:0] m);
		logic ok;
		ok = (a.kind == m[1:0]);
		ok = ok & (a.length == m[3:2]);
		ok = ok & (~m[5] | a.io) & (~m[6] | a.lock);
		ok = ok & (~m[7] | a.cacheable) & (~m[8] | a.split);
		ok = ok & (a.demand == m[9]) & (~m[10] | a.ordered);
		ok = ok & (a.memory_kind == m[13:11]);
		ok = ok & ((m[13] & a.from_self) | (m[14] & ~a.from_self));
		return ok;
	endfunction

	// Entries that hardware adds: an L2 writeback gets its own entry and a
	// write-back read spawns an adjacent sector prefetch one clock later.
	baeq_pkg::baeq_alloc_type pf_ent;
	baeq_pkg::baeq_alloc_type wb_ent;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pf_pend <= 1'b0;
			wb_pend <= 1'b0;
			pf_ent  <= '0;
			wb_ent  <= '0;
		end else begin
			pf_pend <= alloc_valid_i && alloc_i.kind == 2'h0
				&& alloc_i.memory_kind == `BAEQ_MEM_WB
				&& alloc_i.demand;
			pf_ent  <= alloc_i;
			pf_ent.demand <= 1'b0;
			wb_pend <= alloc_valid_i & alloc_i.l2_writeback;
			wb_ent  <= alloc_i;
			wb_ent.kind <= 2'h3;
		end
	end

	// Chunk entries are requests under a line; the bytes field tells.
	logic chunk;
	assign chunk = alloc_i.bytes < `BAEQ_LINE_BYTES;

	// Keep the class of the last allocation so software can see it in the
	// status word; it holds until the next allocation replaces it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chunk_q <= 1'b0;
		end else if (alloc_valid_i) begin
			chunk_q <= chunk;
		end
	end
	assign hit_q = queue_mode & ((alloc_valid_i & qmatch(alloc_i, mq))
		| (pf_pend & qmatch(pf_ent, mq))
		| (wb_pend & qmatch(wb_ent, mq)));

	////////////////////////////////////////////////////////////////////////
	// Older in-order trigger: memory bits ignored with read/write-all.
	// Privilege level is not looked at.
	logic ioq_req;
	logic ioq_mem;
	assign ioq_req = (ioq_i.kind == mq[4:0]) | (mq[5] & ioq_i.is_read)
		| (mq[6] & ioq_i.is_write);
	assign ioq_mem = (mq[5] | mq[6]) ? 1'b0
		: |(ioq_i.memory_onehot & mq[11:7]);
	assign hit_i = ioq_valid_i & (ioq_req | ioq_mem)
		& ((mq[13] & ioq_i.from_self) | (mq[14] & ~ioq_i.from_self));

	////////////////////////////////////////////////////////////////////////
	// Edge history for the rising-edge qualification.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hit_dq <= 1'b0;
			hit_qq <= 1'b0;
			hit_iq <= 1'b0;
		end else begin
			hit_dq <= hit_d;
			hit_qq <= hit_q;
			hit_iq <= hit_i;
		end
	end

	assign data_event_o  = hit_d & ~(edge_d & hit_dq);
	assign queue_event_o = hit_q & ~(edge_q & hit_qq);

	// Counters advance on each qualified event.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_d <= '0;
			cnt_q <= '0;
			cnt_i <= '0;
		end else begin
			if (data_event_o) begin
				cnt_d <= cnt_d + 1'b1;
			end
			if (queue_event_o) begin
				cnt_q <= cnt_q + 1'b1;
			end
			if (hit_i & ~(edge_q & hit_iq)) begin
				cnt_i <= cnt_i + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_excl;
		@(posedge clk_i) disable iff (rst_i)
		!(cond[1] && cond[2]) && !(cond[4] && cond[5]);
	endproperty
	a_excl: assert property (p_excl)
		else $error("Owned and other conditions both set.");
	property p_edge;
		@(posedge clk_i) disable iff (rst_i)
		(edge_d && hit_d && $past(hit_d)) |-> !data_event_o;
	endproperty
	a_edge: assert property (p_edge)
		else $error("Edge mode counted a held condition.");
	property p_cnt;
		@(posedge clk_i) disable iff (rst_i)
		data_event_o |=> cnt_d == $past(cnt_d) + 1'b1;
	endproperty
	a_cnt: assert property (p_cnt)
		else $error("Data counter missed an event.");
	// A held condition in level mode must move the counter every clock.
	property p_level;
		@(posedge clk_i) disable iff (rst_i)
		(!edge_d && hit_d) |=> cnt_d != $past(cnt_d);
	endproperty
	a_level: assert property (p_level)
		else $error("Level mode dropped an event.");
	property p_pf;
		@(posedge clk_i) disable iff (rst_i)
		(alloc_valid_i && alloc_i.kind == 2'h0 && alloc_i.demand
		&& alloc_i.memory_kind == `BAEQ_MEM_WB) |=> pf_pend;
	endproperty
	a_pf: assert property (p_pf)
		else $error("No adjacent prefetch entry.");
	property p_wb;
		@(posedge clk_i) disable iff (rst_i)
		(alloc_valid_i && alloc_i.l2_writeback) |=> wb_pend;
	endproperty
	a_wb: assert property (p_wb)
		else $error("Writeback entry missing.");
	// Without the data code the counter must stand still.
	property p_off;
		@(posedge clk_i) disable iff (rst_i)
		!data_mode |=> cnt_d == $past(cnt_d);
	endproperty
	a_off: assert property (p_off)
		else $error("Counted with wrong select code.");
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		s_req |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("Bus answer timing wrong.");
endmodule
`default_nettype wire

//--- testbench/baeq_agents.sv
// Model of the other bus agents: data phase pins and queue allocations.
// Assumes the bench calls its tasks one at a time, in step with clk_i.
`timescale 1ns/1ps
`default_nettype none
module baeq_agents (
	input  wire logic                   clk_i,
	output var baeq_pkg::baeq_phase_type phase_o,
	output logic                        alloc_valid_o,
	output var baeq_pkg::baeq_alloc_type alloc_o,
	output logic                        ioq_valid_o,
	output var baeq_pkg::baeq_ioq_type   ioq_o
);
	////////////////////////////////////////////////////////////////////////
	// Bus lines idle inactive; payloads start cleared.
	initial begin
		phase_o = '0;
		alloc_valid_o = 1'b0;
		alloc_o = '0;
		ioq_valid_o = 1'b0;
		ioq_o = '0;
	end

	// Pattern a for n clocks, then b for n2 clocks, then idle lines.
	// Sampled and unsampled are one flag, so never both true.
	task automatic burst(input logic [3:0] a, input int n,
		input logic [3:0] b, input int n2);
		repeat (n) begin
			@(posedge clk_i);
			phase_o <= baeq_pkg::baeq_phase_type'(a);
		end
		repeat (n2) begin
			@(posedge clk_i);
			phase_o <= baeq_pkg::baeq_phase_type'(b);
		end
		@(posedge clk_i);
		phase_o <= '0;
		repeat (5) @(posedge clk_i);
	endtask

	// One allocation pulse; the payload is scrambled once it is stale.
	task automatic alloc(input baeq_pkg::baeq_alloc_type a);
		@(posedge clk_i);
		alloc_valid_o <= 1'b1;
		alloc_o <= a;
		@(posedge clk_i);
		alloc_valid_o <= 1'b0;
		alloc_o <= ~a;
		repeat (3) @(posedge clk_i);
	endtask

	// One in-order queue allocation pulse.
	task automatic ioq(input baeq_pkg::baeq_ioq_type q);
		@(posedge clk_i);
		ioq_valid_o <= 1'b1;
		ioq_o <= q;
		@(posedge clk_i);
		ioq_valid_o <= 1'b0;
		ioq_o <= ~q;
		repeat (3) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the bus activity event qualifier.
// Assumes the agent model drives the bus side and Wishbone reads counts.
`timescale 1ns/1ps
`include "baeq_regs.svh"
`default_nettype none
module tb_top;
	logic                     clk_i = 1'b0;
	logic                     rst_i = 1'b1;
	logic                     cyc_i = 1'b0;
	logic                     stb_i = 1'b0;
	logic                     we_i = 1'b0;
	logic [7:0]               adr_i = 8'h00;
	logic [3:0]               sel_i = 4'h0;
	logic [31:0]              dat_i = 32'h0000_0000;
	logic [31:0]              dat_o;
	logic                     ack_o, data_event_o, queue_event_o;
	logic                     alloc_valid_i, ioq_valid_i;
	baeq_pkg::baeq_phase_type phase_i;
	baeq_pkg::baeq_alloc_type alloc_i;
	baeq_pkg::baeq_ioq_type   ioq_i;
	logic [31:0]              base [8] = '{default: 32'h0000_0000};
	logic [31:0]              ev_d = 32'h0000_0000;
	logic [31:0]              ev_q = 32'h0000_0000;
	int                       errors = 0;
	int                       checks = 0;
	int                       cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// A 40 MHz clock.
	always #12.5 clk_i = ~clk_i;

	baeq_top i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .phase_i, .alloc_valid_i, .alloc_i,
		.ioq_valid_i, .ioq_i, .data_event_o, .queue_event_o);
	baeq_agents i_agents (.clk_i, .phase_o(phase_i),
		.alloc_valid_o(alloc_valid_i), .alloc_o(alloc_i),
		.ioq_valid_o(ioq_valid_i), .ioq_o(ioq_i));

	// Event pulses are tallied apart from the counters to judge the outputs.
	always @(posedge clk_i) begin
		if (!rst_i) begin
			ev_d <= ev_d + 32'(data_event_o);
			ev_q <= ev_q + 32'(queue_event_o);
		end
	end

	// The run needs a few hundred cycles; a hang is cut short here.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			results();
		end
	end

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h",
				$time, what, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Classic cycle: hold everything until ack is seen at an edge.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		@(posedge clk_i);
		while (ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	// Counts are judged as growth since that counter's last snapshot.
	task automatic cnt(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(q - base[a[4:2]], e, "count growth");
		base[a[4:2]] = q;
	endtask

	task automatic cfg(input logic [2:0] c, input logic e);
		wr(`BAEQ_OFF_CFG, {16'h0000, c, 12'h000, e});
	endtask

	function automatic logic [15:0] qm(input logic [1:0] k,
		input logic [1:0] l, input logic [2:0] m, input logic d);
		qm = {2'h1, m, 1'b0, d, 5'h00, l, k};
	endfunction

	function automatic baeq_pkg::baeq_alloc_type mk(input logic [1:0] k,
		input logic [1:0] l, input logic [2:0] m, input logic d);
		mk = '0;
		mk.kind = k;
		mk.length = l;
		mk.memory_kind = m;
		mk.demand = d;
		mk.bytes = (l == 2'h3) ? `BAEQ_LINE_BYTES : 7'h08;
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] q;
		wb(1'b0, `BAEQ_OFF_CFG, 32'h0000_0000, q);
		chk(q, `BAEQ_CFG_RST, "config reset");
		wr(8'h1c, 32'hffff_ffff);
		wb(1'b0, 8'h1c, 32'h0000_0000, q);
		chk(q, 32'h0000_0000, "unmapped read");
		wr(`BAEQ_OFF_SEL_A, 32'h2e00_0200);
		wb(1'b0, `BAEQ_OFF_SEL_A, 32'h0000_0000, q);
		chk(q, 32'h2e00_0200, "selector readback");
	endtask

	// Each mask bit: its condition counts per clock, a near miss does not.
	task automatic t_data;
		logic [3:0] m[6] = '{4'ha, 4'h9, 4'h8, 4'h6, 4'h5, 4'h4};
		logic [3:0] x[6] = '{4'h8, 4'h8, 4'h9, 4'h4, 4'h4, 4'h5};
		cfg(`BAEQ_CFG_DATA, 1'b0);
		for (int b = 0; b < 6; b++) begin
			wr(`BAEQ_OFF_SEL_A, {`BAEQ_CODE_DATA, 16'h0001 << b, 9'h000});
			cnt(`BAEQ_OFF_CNT_D, 32'h0000_0000);
			i_agents.burst(m[b], 2, x[b], 2);
			cnt(`BAEQ_OFF_CNT_D, 32'h0000_0002);
		end
	endtask

	task automatic t_edge;
		cfg(`BAEQ_CFG_DATA, 1'b1);
		wr(`BAEQ_OFF_SEL_A, {`BAEQ_CODE_DATA, 16'h0001, 9'h000});
		cnt(`BAEQ_OFF_CNT_D, 32'h0000_0000);
		i_agents.burst(4'ha, 4, 4'h0, 0);
		i_agents.burst(4'ha, 2, 4'h0, 0);
		cnt(`BAEQ_OFF_CNT_D, 32'h0000_0002);
		cfg(`BAEQ_CFG_QUEUE, 1'b0);
		i_agents.burst(4'ha, 2, 4'h0, 0);
		cnt(`BAEQ_OFF_CNT_D, 32'h0000_0000);
		chk(ev_d, 32'h0000_000e, "data event pulses");
	endtask

	// Every memory kind and request kind, one match and one demand miss.
	task automatic t_queue;
		logic [2:0] mk_t[5] = '{`BAEQ_MEM_UC, `BAEQ_MEM_WC, `BAEQ_MEM_WT,
			`BAEQ_MEM_WP, `BAEQ_MEM_WB};
		logic [1:0] ln[5] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h3};
		logic [31:0] q;
		cfg(`BAEQ_CFG_QUEUE, 1'b0);
		cnt(`BAEQ_OFF_CNT_Q, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			wr(`BAEQ_OFF_SEL_Q, {`BAEQ_CODE_QUEUE,
				qm(2'(i % 4), ln[i], mk_t[i], 1'b1), 9'h000});
			i_agents.alloc(mk(2'(i % 4), ln[i], mk_t[i], 1'b1));
			i_agents.alloc(mk(2'(i % 4), ln[i], mk_t[i], 1'b0));
			cnt(`BAEQ_OFF_CNT_Q, 32'h0000_0001);
		end
		wb(1'b0, `BAEQ_OFF_STAT, 32'h0000_0000, q);
		chk(q, 32'h0000_0002, "line entry status");
	endtask

	// Required qualifier, source agent, extra writeback and prefetch.
	task automatic t_qual;
		baeq_pkg::baeq_alloc_type a;
		logic [31:0] q;
		wr(`BAEQ_OFF_SEL_Q, {`BAEQ_CODE_QUEUE,
			qm(2'h2, 2'h1, 3'h0, 1'b1) | 16'h0020, 9'h000});
		a = mk(2'h2, 2'h1, 3'h0, 1'b1);
		i_agents.alloc(a);
		cnt(`BAEQ_OFF_CNT_Q, 32'h0000_0000);
		wb(1'b0, `BAEQ_OFF_STAT, 32'h0000_0000, q);
		chk(q, 32'h0000_0012, "chunk entry status");
		a.io = 1'b1;
		i_agents.alloc(a);
		cnt(`BAEQ_OFF_CNT_Q, 32'h0000_0001);
		a.from_self = 1'b1;
		i_agents.alloc(a);
		cnt(`BAEQ_OFF_CNT_Q, 32'h0000_0000);
		wr(`BAEQ_OFF_SEL_Q, {`BAEQ_CODE_QUEUE,
			qm(2'h3, 2'h1, 3'h0, 1'b1), 9'h000});
		a = mk(2'h2, 2'h1, 3'h0, 1'b1);
		a.l2_writeback = 1'b1;
		i_agents.alloc(a);
		cnt(`BAEQ_OFF_CNT_Q, 32'h0000_0001);
		wr(`BAEQ_OFF_SEL_Q, {`BAEQ_CODE_QUEUE,
			qm(2'h0, 2'h3, `BAEQ_MEM_WB, 1'b0), 9'h000});
		i_agents.alloc(mk(2'h0, 2'h3, `BAEQ_MEM_WB, 1'b1));
		cnt(`BAEQ_OFF_CNT_Q, 32'h0000_0001);
		chk(ev_q, 32'h0000_0008, "queue event pulses");
	endtask

	task automatic t_ioq;
		wr(`BAEQ_OFF_SEL_Q, {`BAEQ_CODE_QUEUE, 16'h4020, 9'h000});
		cnt(`BAEQ_OFF_IOQ, 32'h0000_0000);
		i_agents.ioq({5'h1f, 2'h2, 5'h01, 1'b0, 2'h3});
		i_agents.ioq({5'h1f, 2'h2, 5'h01, 1'b0, 2'h0});
		cnt(`BAEQ_OFF_IOQ, 32'h0000_0002);
		i_agents.ioq({5'h1f, 2'h2, 5'h01, 1'b1, 2'h0});
		wr(`BAEQ_OFF_SEL_Q, {`BAEQ_CODE_QUEUE, 16'h40a0, 9'h000});
		i_agents.ioq({5'h1f, 2'h1, 5'h01, 1'b0, 2'h0});
		cnt(`BAEQ_OFF_IOQ, 32'h0000_0000);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset for three clocks, then every scenario in turn.
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_data();
		t_edge();
		t_queue();
		t_qual();
		t_ioq();
		results();
	end
endmodule
`default_nettype wire
